/* src/sdc_cal_seq.sv */
// self-calibration sequencer with avalon-mm register slave
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
// Summary of operation
// - modulator rate clk/128, decimated to output rate
// - calibration starts only on a setup write with mode pattern 0,1
// - calibration converts zero and full points
// - results stored in zero/full calibration registers
// - 33-bit offset and gain arithmetic, 16-bit words
// - mode pattern 0,1 starts self-calibration
// - unipolar zero point uses shorted inputs
// - zero point uses selected gain
// - full point on reference over gain
// - six periods: three zero, three full
// - mode bits cleared when conversions finish
// - ready high from start until new word
// - ready low nine periods after command
// - ready rises within one modulator cycle
// - bipolar maps shorted point to midscale
// - rate select sets output update rate

`include "sdc_defines.svh"

module sdc_cal_seq
	import sdc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        mod_bit,
	output logic             ready_low_flag_n,
	output logic             short_inputs,
	output logic             ref_cal_sel,
	output logic [1:0]       gain_select,
	output logic             irq
);

	// ==========================================================
	// helpers

	// decimation length for a rate select code
	function automatic logic [`SDC_DEC_W-1:0] sdc_dec_len(input logic [1:0] rate);
		logic [`SDC_DEC_W-1:0] len;
		len = `SDC_DEC_LEN0;
		unique case (rate)
			2'h0: len = `SDC_DEC_LEN0;
			2'h1: len = `SDC_DEC_LEN1;
			2'h2: len = `SDC_DEC_LEN2;
			2'h3: len = `SDC_DEC_LEN3;
		endcase
		return len;
	endfunction : sdc_dec_len

	// offset and slope correction of a raw reading
	function automatic logic [15:0] sdc_scale(
		input logic [15:0] raw,
		input logic [15:0] zs,
		input logic [15:0] fs,
		input logic        unip
	);
		logic signed [32:0] num;
		logic signed [32:0] den;
		logic signed [32:0] q;
		logic [15:0]        res;
		num = $signed({17'h0, raw}) - $signed({17'h0, zs});
		den = $signed({17'h0, fs}) - $signed({17'h0, zs});
		q   = 33'sh0;
		res = 16'h0000;
		if (unip) begin
			num = num * 33'sh0ffff;
		end else begin
			num = num * 33'sh07fff;
		end
		if (den > 33'sh0) begin
			q = num / den;
		end
		if (!unip) begin
			q = q + 33'sh08000;
		end
		if (den <= 33'sh0 || q < 33'sh0) begin
			res = 16'h0000;
		end else if (q > 33'sh0ffff) begin
			res = 16'hffff;
		end else begin
			res = q[15:0];
		end
		return res;
	endfunction : sdc_scale

	// ==========================================================
	// state

	sdc_regs_t r;
	sdc_regs_t n;

	logic                  mod_tick;
	logic                  per_done;
	logic [`SDC_DEC_W-1:0] samp;
	logic [15:0]           raw;
	logic [15:0]           conv;
	logic                  acc_ok;
	logic                  wr_now;
	logic                  rd_now;
	logic                  cal_go;

	// ==========================================================
	// decimator timing and access decode
	always_comb begin
		mod_tick = (r.mdiv_q == `SDC_MOD_DIV_W'(`SDC_MOD_DIV - 1));
		samp     = r.acc_q + {{(`SDC_DEC_W-1){1'b0}}, mod_bit};
		per_done = mod_tick && (r.scnt_q == sdc_dec_len(r.rate_q) - `SDC_DEC_W'(1));
		raw      = {{(16-`SDC_DEC_W){1'b0}}, samp};
		conv     = sdc_scale(raw, r.zs_q, r.fs_q, r.unip_q);
		acc_ok   = !r.wait_q;
		wr_now   = avs_write && acc_ok;
		rd_now   = avs_read && acc_ok;
		cal_go   = wr_now && (avs_address == `SDC_OFS_SETUP)
		           && (avs_writedata[`SDC_MODE_HI:`SDC_MODE_LO] == `SDC_MODE_SELF);
	end

	// ==========================================================
	// next state
	always_comb begin
		n = r;

		// bus handshake: one wait cycle, answer on the second
		n.wait_q = 1'b1;
		if ((avs_read || avs_write) && r.wait_q) begin
			n.wait_q = 1'b0;
		end
		if (avs_read && r.wait_q) begin
			n.rdata_q = 32'h0000_0000;
			unique case (avs_address)
				`SDC_OFS_SETUP: begin
					n.rdata_q[`SDC_MODE_HI:`SDC_MODE_LO] = r.mode_q;
					n.rdata_q[`SDC_GAIN_HI:`SDC_GAIN_LO] = r.gain_q;
					n.rdata_q[`SDC_UNIP_BIT]            = r.unip_q;
				end
				`SDC_OFS_CLOCK:    n.rdata_q[1:0]  = r.rate_q;
				`SDC_OFS_DATA:     n.rdata_q[15:0] = r.data_q;
				`SDC_OFS_ZERO_CAL: n.rdata_q[15:0] = r.zs_q;
				`SDC_OFS_FULL_CAL: n.rdata_q[15:0] = r.fs_q;
				`SDC_OFS_IRQ_STS:  n.rdata_q[1:0]  = r.sts_q;
				`SDC_OFS_IRQ_EN:   n.rdata_q[1:0]  = r.ien_q;
				default:           n.rdata_q       = 32'h0000_0000;
			endcase
		end

		// reading the data word releases ready
		if (rd_now && avs_address == `SDC_OFS_DATA) begin
			n.rdy_n_q = 1'b1;
		end

		// register writes
		if (wr_now) begin
			unique case (avs_address)
				`SDC_OFS_SETUP: begin
					n.mode_q = avs_writedata[`SDC_MODE_HI:`SDC_MODE_LO];
					n.gain_q = avs_writedata[`SDC_GAIN_HI:`SDC_GAIN_LO];
					n.unip_q = avs_writedata[`SDC_UNIP_BIT];
				end
				`SDC_OFS_CLOCK:    n.rate_q = avs_writedata[1:0];
				`SDC_OFS_ZERO_CAL: n.zs_q   = avs_writedata[15:0];
				`SDC_OFS_FULL_CAL: n.fs_q   = avs_writedata[15:0];
				`SDC_OFS_IRQ_EN:   n.ien_q  = avs_writedata[1:0];
				`SDC_OFS_IRQ_CLR:  n.sts_q  = r.sts_q & ~avs_writedata[1:0];
				default: begin
				end
			endcase
		end

		// modulator divider and decimating accumulator
		n.mdiv_q = mod_tick ? '0 : r.mdiv_q + `SDC_MOD_DIV_W'(1);
		if (mod_tick) begin
			if (per_done) begin
				n.scnt_q = '0;
				n.acc_q  = '0;
			end else begin
				n.scnt_q = r.scnt_q + `SDC_DEC_W'(1);
				n.acc_q  = samp;
			end
		end

		// sequencer, advanced once per output period
		if (per_done) begin
			unique case (r.st_q)
				ST_CONV: begin
					if (r.mode_q == `SDC_MODE_NORMAL) begin
						n.data_q              = conv;
						n.rdy_n_q             = 1'b0;
						n.sts_q[`SDC_IRQ_DATA] = 1'b1;
					end
				end
				ST_ZS: begin
					n.pcnt_q = r.pcnt_q + 2'd1;
					if (r.pcnt_q == `SDC_PHASE_PERIODS - 2'd1) begin
						n.zs_q     = raw;
						n.st_q     = ST_FS;
						n.pcnt_q   = 2'd0;
						n.short_q  = 1'b0;
						n.refsel_q = 1'b1;
					end
				end
				ST_FS: begin
					n.pcnt_q = r.pcnt_q + 2'd1;
					if (r.pcnt_q == `SDC_PHASE_PERIODS - 2'd1) begin
						n.fs_q                = raw;
						n.mode_q              = `SDC_MODE_NORMAL;
						n.sts_q[`SDC_IRQ_CAL] = 1'b1;
						n.st_q                = ST_SETTLE;
						n.pcnt_q              = 2'd0;
						n.refsel_q            = 1'b0;
					end
				end
				ST_SETTLE: begin
					n.pcnt_q = r.pcnt_q + 2'd1;
					if (r.pcnt_q == `SDC_PHASE_PERIODS - 2'd1) begin
						n.data_q               = conv;
						n.rdy_n_q              = 1'b0;
						n.sts_q[`SDC_IRQ_DATA] = 1'b1;
						n.st_q                 = ST_CONV;
						n.pcnt_q               = 2'd0;
					end
				end
			endcase
		end

		// a calibration command restarts sequencer, divider, accumulator, ready and input selects at once
		if (cal_go) begin
			n.st_q     = ST_ZS;
			n.pcnt_q   = 2'd0;
			n.mdiv_q   = '0;
			n.scnt_q   = '0;
			n.acc_q    = '0;
			n.rdy_n_q  = 1'b1;
			n.short_q  = 1'b1;
			n.refsel_q = 1'b0;
		end

		// irq bits stay set when a clear meets a new event
		n.irq_q = |(n.sts_q & r.ien_q);
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			r          <= '0;
			r.wait_q   <= 1'b1;
			r.rdy_n_q  <= 1'b1;
			r.zs_q     <= `SDC_RST_ZERO_CAL;
			r.fs_q     <= `SDC_RST_FULL_CAL;
			r.rate_q   <= `SDC_RST_RATE;
			r.unip_q   <= 1'b1;
			r.st_q     <= ST_CONV;
		end else begin
			r <= n;
		end
	end

	// ==========================================================
	// outputs straight from flops
	assign avs_readdata     = r.rdata_q;
	assign avs_waitrequest  = r.wait_q;
	assign ready_low_flag_n = r.rdy_n_q;
	assign short_inputs     = r.short_q;
	assign ref_cal_sel      = r.refsel_q;
	assign gain_select      = r.gain_q;
	assign irq              = r.irq_q;

endmodule : sdc_cal_seq

/* src/sdc_defines.svh */
// constants of the self-calibration sequencer
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH

// ==========================================================
// clocking
`define SDC_CLKIN_HZ      2457600
`define SDC_MOD_RATE_HZ   19200
`define SDC_MOD_DIV       (`SDC_CLKIN_HZ / `SDC_MOD_RATE_HZ)
`define SDC_MOD_DIV_W     7

// ==========================================================
// decimation lengths per rate select code
`define SDC_DEC_W         10
`define SDC_DEC_LEN0      10'd960
`define SDC_DEC_LEN1      10'd768
`define SDC_DEC_LEN2      10'd192
`define SDC_DEC_LEN3      10'd96
`define SDC_PHASE_PERIODS 2'd3

// ==========================================================
// register byte offsets
`define SDC_OFS_SETUP     5'h00
`define SDC_OFS_CLOCK     5'h04
`define SDC_OFS_DATA      5'h08
`define SDC_OFS_ZERO_CAL  5'h0c
`define SDC_OFS_FULL_CAL  5'h10
`define SDC_OFS_IRQ_STS   5'h14
`define SDC_OFS_IRQ_EN    5'h18
`define SDC_OFS_IRQ_CLR   5'h1c

// ==========================================================
// setup fields and codes
`define SDC_MODE_HI       7
`define SDC_MODE_LO       6
`define SDC_GAIN_HI       4
`define SDC_GAIN_LO       3
`define SDC_UNIP_BIT      2
`define SDC_MODE_NORMAL   2'h0
`define SDC_MODE_SELF     2'h1

// ==========================================================
// reset values
`define SDC_RST_ZERO_CAL  16'h0000
`define SDC_RST_FULL_CAL  16'h0060
`define SDC_RST_RATE      2'h3

// ==========================================================
// interrupt bits
`define SDC_IRQ_DATA      0
`define SDC_IRQ_CAL       1

`endif

/* src/sdc_pkg.sv */
// types of the self-calibration sequencer
`include "sdc_defines.svh"
package sdc_pkg;

	// sequencer states
	typedef enum logic [1:0] {
		ST_CONV,
		ST_ZS,
		ST_FS,
		ST_SETTLE
	} sdc_state_t;

	// whole block state
	typedef struct packed {
		logic                      wait_q;
		logic [31:0]               rdata_q;
		logic [1:0]                mode_q;
		logic [1:0]                gain_q;
		logic                      unip_q;
		logic [1:0]                rate_q;
		logic [15:0]               data_q;
		logic [15:0]               zs_q;
		logic [15:0]               fs_q;
		logic [1:0]                sts_q;
		logic [1:0]                ien_q;
		logic                      irq_q;
		logic                      rdy_n_q;
		logic [`SDC_MOD_DIV_W-1:0] mdiv_q;
		logic [`SDC_DEC_W-1:0]     scnt_q;
		logic [`SDC_DEC_W-1:0]     acc_q;
		sdc_state_t                st_q;
		logic [1:0]                pcnt_q;
		logic                      short_q;
		logic                      refsel_q;
	} sdc_regs_t;

endpackage : sdc_pkg

/* verif/sdc_cal_seq_properties.sv */
// port assertions of the self-calibration sequencer
`timescale 1ns/100ps
module sdc_cal_seq_properties (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        mod_bit,
	input wire logic        ready_low_flag_n,
	input wire logic        short_inputs,
	input wire logic        ref_cal_sel,
	input wire logic [1:0]  gain_select,
	input wire logic        irq
);
	// ==========================================================
	// phase length counters, restarted by each calibration command
	logic        cmd;
	logic [16:0] zs_len_q;
	logic [16:0] fs_len_q;
	assign cmd = avs_write && !avs_waitrequest && avs_address == 5'h00 && avs_writedata[7:6] == 2'h1;
	always_ff @(posedge clk_sys) begin
		zs_len_q <= (rst || cmd) ? 17'h0 : zs_len_q + {16'h0, short_inputs};
		fs_len_q <= (rst || cmd) ? 17'h0 : fs_len_q + {16'h0, ref_cal_sel};
	end

	// ==========================================================
	// assertions
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest not lowered after request");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_cal_start: assert property (cmd |=> ready_low_flag_n && short_inputs && !ref_cal_sel)
		else $error("calibration command did not start zero phase");
	a_gain_follow: assert property (avs_write && !avs_waitrequest && avs_address == 5'h00 |=>
		gain_select == $past(avs_writedata[4:3])) else $error("gain select does not follow setup");
	a_cal_exclusive: assert property (!(short_inputs && ref_cal_sel))
		else $error("zero and full phase together");
	a_ready_held: assert property (short_inputs || ref_cal_sel |-> ready_low_flag_n)
		else $error("ready low during calibration");
	a_zero_len: assert property ($fell(short_inputs) |-> ref_cal_sel && zs_len_q inside {[17'd36863:17'd36865]})
		else $error("zero phase length wrong");
	a_full_len: assert property ($fell(ref_cal_sel) |-> fs_len_q inside {[17'd36863:17'd36865]})
		else $error("full phase length wrong");
	a_irq_masked: assert property (avs_write && !avs_waitrequest && avs_address == 5'h18 &&
		avs_writedata[1:0] == 2'h0 |-> ##2 !irq) else $error("irq high with all events disabled");
endmodule : sdc_cal_seq_properties

/* verif/sdc_mod_model.sv */
// modulator bitstream model steered by the calibration input selects
`timescale 1ns/100ps
module sdc_mod_model (
	input  wire logic clk_sys,
	input  wire logic short_inputs,
	input  wire logic ref_cal_sel,
	output logic      mod_bit
);
	logic [8:0] cnt_q = 9'h000;
	// free count, bits 8:7 step once per modulator sample
	always_ff @(posedge clk_sys) begin
		cnt_q <= cnt_q + 9'h001;
	end
	// quarter ones when shorted, three quarters on reference, half on live input
	always_comb begin
		if (short_inputs) begin
			mod_bit = cnt_q[8] & cnt_q[7];
		end else if (ref_cal_sel) begin
			mod_bit = ~(cnt_q[8] & cnt_q[7]);
		end else begin
			mod_bit = cnt_q[7];
		end
	end
endmodule : sdc_mod_model

/* verif/sdc_cal_seq_bench.sv */
// testbench of the self-calibration sequencer
`timescale 1ns/100ps
module sdc_cal_seq_bench;
	localparam int PER = 96 * 128; // output period at rate code 3
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic [31:0] rd;
	logic [1:0]  gain_select;
	logic        avs_waitrequest, mod_bit, ready_low_flag_n, short_inputs, ref_cal_sel, irq;
	int          miscompares = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          t1;

	sdc_cal_seq i_dut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .mod_bit, .ready_low_flag_n, .short_inputs, .ref_cal_sel, .gain_select, .irq);
	sdc_mod_model i_mod (.clk_sys, .short_inputs, .ref_cal_sel, .mod_bit);

	// ==========================================================
	// clock and cycle ceiling
	initial forever #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 150000) begin
			miscompares++;
			finish_test();
		end
	end

	// ==========================================================
	// bus access, compare and closing tasks
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask : bus
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rchk
	task automatic wait_ready(input int lim);
		for (int i = 0; i < lim && ready_low_flag_n !== 1'b0; i++) @(posedge clk_sys);
	endtask : wait_ready
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : finish_test

	// ==========================================================
	// main sequence
	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rchk(5'h00, 32'h04);
		rchk(5'h04, 32'h03);
		rchk(5'h0c, 32'h00);
		rchk(5'h10, 32'h60);
		rchk(5'h1c, 32'h00);
		bus(1'b1, 5'h18, 32'h1);
		// normal conversions, one word each period
		wait_ready(2 * PER);
		t1 = cyc;
		chk(32'(irq), 32'h1);
		rchk(5'h08, 32'h7fff);
		chk(32'(ready_low_flag_n), 32'h1);
		bus(1'b1, 5'h1c, 32'h1);
		wait_ready(2 * PER);
		chk(cyc - t1, PER);
		bus(1'b1, 5'h1c, 32'h1);
		// self-calibration at gain 2 while ready is still low
		bus(1'b1, 5'h00, 32'h54);
		t1 = cyc;
		chk(32'(ready_low_flag_n), 32'h1);
		chk(32'(short_inputs), 32'h1);
		chk(32'(gain_select), 32'h2);
		repeat (4 * PER) @(posedge clk_sys);
		chk({short_inputs, ref_cal_sel}, 32'h1);
		repeat (3 * PER) @(posedge clk_sys);
		rchk(5'h00, 32'h14);
		rchk(5'h0c, 32'h18);
		rchk(5'h10, 32'h48);
		rchk(5'h14, 32'h2);
		chk(32'(irq), 32'h0);
		bus(1'b1, 5'h18, 32'h3);
		// irq follows the new enable one edge after the write lands
		@(posedge clk_sys);
		chk(32'(irq), 32'h1);
		chk(32'(ready_low_flag_n), 32'h1);
		wait_ready(3 * PER);
		chk(32'((cyc - t1) inside {[9 * PER - 4 : 9 * PER + 4]}), 32'h1);
		rchk(5'h08, 32'h7fff);
		bus(1'b1, 5'h18, 32'h0);
		repeat (2) @(posedge clk_sys);
		chk(32'(irq), 32'h0);
		finish_test();
	end
endmodule : sdc_cal_seq_bench

bind sdc_cal_seq sdc_cal_seq_properties i_props (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
	.avs_readdata, .avs_waitrequest, .mod_bit, .ready_low_flag_n, .short_inputs, .ref_cal_sel, .gain_select, .irq);
